// ==== core/tlm_pkg.sv ====
/*
  Package for the top-level master register block: register indices,
  field positions, reset values and system-side option codes.
  Assumes a 32-bit APB bus with one aligned word per 8-bit register.
*/
package tlm_pkg;
    // ==========================================================
    // Register indices (byte address is four times the index)
    localparam int IDX_W = 13;
    localparam logic [12:0] IDX_REVISION = 13'h0000;
    localparam logic [12:0] IDX_GLOBAL_RESET = 13'h0001;
    localparam logic [12:0] IDX_GLOBAL_CONFIG = 13'h0002;
    localparam logic [12:0] IDX_STATUS = 13'h0003;
    localparam logic [12:0] IDX_MAP_QUERY = 13'h0004;
    localparam logic [12:0] IDX_MAP_TELECOM = 13'h0005;
    localparam logic [12:0] IDX_MAP_M13 = 13'h0006;
    localparam logic [12:0] IDX_MAP_HMVIP = 13'h0007;
    localparam int TEST_SEL_BIT = 12;
    // ==========================================================
    // Field positions
    localparam int SWRST_BIT = 0;
    localparam int MASTER_INTERRUPT_ENABLE_BIT = 7;
    localparam int SYSOPT_LSB = 0;
    localparam int QRY_E1_BIT = 7;
    localparam int QRY_SPE_LSB = 5;
    // ==========================================================
    // System-side option codes and reset values
    localparam logic [1:0] SYSOPT_RESERVED = 2'h0;
    localparam logic [1:0] SYSOPT_HMVIP = 2'h1;
    localparam logic [1:0] SYSOPT_SBI = 2'h2;
    localparam logic [1:0] SYSOPT_SBI_HMVIP = 2'h3;
    localparam logic [1:0] SYSOPT_RESET = SYSOPT_SBI;
    localparam logic [7:0] GLOBAL_RESET_RESET = 8'h00;
    localparam logic [7:0] MAP_QUERY_RESET = 8'h00;
    localparam logic [2:0] OPMODE_HD_FRAMER = 3'h0;
    // ==========================================================
    // Tributary structure
    localparam int NUM_SPE = 3;
    localparam int TUG2_PER_SPE = 7;
    localparam int T1_PER_DS2 = 4;
    localparam int E1_PER_DS2 = 3;
    localparam int T1_LINKS = 28;
    localparam int E1_LINKS = 21;
endpackage : tlm_pkg

// ==== core/tlm_trib_map.sv ====
/*
  Tributary index translator: system-bus SPE and link number to
  telecom-bus, M13 and H-MVIP indices. Purely combinational.
  Assumes the caller registers the results.
*/
`timescale 1ns/1ps
`default_nettype none
module tlm_trib_map (
    input wire logic [1:0] spe_idx,
    input wire logic [4:0] link_idx,
    input wire logic e1_mode,
    output logic [2:0] tug2_idx,
    output logic [2:0] tu_idx,
    output logic [2:0] ds2_idx,
    output logic [2:0] sub_idx,
    output logic [4:0] port_idx,
    output logic valid
);
    // ==========================================================
    // Index arithmetic
    logic [4:0] lnk0;
    logic [4:0] per_ds2;
    logic [4:0] max_link;
    // Link number decomposed both ways
    always_comb begin
        lnk0 = link_idx - 5'h01;
        per_ds2 = e1_mode ? 5'(tlm_pkg::E1_PER_DS2) : 5'(tlm_pkg::T1_PER_DS2);
        max_link = e1_mode ? 5'(tlm_pkg::E1_LINKS) : 5'(tlm_pkg::T1_LINKS);
        tug2_idx = 3'(lnk0 % 5'(tlm_pkg::TUG2_PER_SPE)) + 3'h1;
        tu_idx = 3'(lnk0 / 5'(tlm_pkg::TUG2_PER_SPE)) + 3'h1;
        ds2_idx = 3'(lnk0 / per_ds2) + 3'h1;
        sub_idx = 3'(lnk0 % per_ds2) + 3'h1;
        port_idx = 5'(5'(tlm_pkg::TUG2_PER_SPE) * 5'(spe_idx - 2'h1)) + 5'(ds2_idx);
        valid = (spe_idx != 2'h0) && (link_idx != 5'h00) && (link_idx <= max_link);
    end
endmodule : tlm_trib_map
`default_nettype wire

// ==== core/tlm_master_regs.sv ====
/*
  Top-level master register bank on APB: revision, global software
  reset, global configuration, status and a tributary index query.
  Assumes an APB master on clk_sys and enabled interrupt sources
  arriving as a level from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tlm_master_regs #(
    parameter logic [3:0] VERSION_CODE = 4'h1, // Arbitrary value
    parameter logic [3:0] TYPE_CODE = 4'h5 // Arbitrary value
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic int_req,
    input wire logic [8:0] spe_operating_mode,
    output logic interrupt_output_n_o,
    output logic interrupt_output_n_oe,
    output logic device_reset,
    output logic standby,
    output logic sbi_select,
    output logic [2:0] hmvip_select,
    output logic option_invalid
);
    // ==========================================================
    // Address decode
    logic [12:0] idx;
    logic test_sel;
    logic aligned;
    logic setup_ph;
    logic wr_en;
    logic pready_ff;
    assign idx = paddr[14:2];
    assign test_sel = idx[tlm_pkg::TEST_SEL_BIT];
    assign aligned = (paddr[1:0] == 2'h0) && (paddr[15] == 1'b0);
    assign setup_ph = psel && !penable;
    // Write takes effect only at the edge that completes the access
    assign wr_en = psel && penable && pready_ff && pwrite && !test_sel && aligned;

    // Decode of a normal-mode register index
    function automatic logic hit(input logic [12:0] a, input logic [12:0] r);
        hit = (a == r);
    endfunction : hit

    // ==========================================================
    // Register state
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    logic swrst_ff;
    logic master_interrupt_enable_ff;
    logic [1:0] sysopt_ff;
    logic [7:0] query_ff;
    logic [2:0] map_tug2_ff;
    logic [2:0] map_tu_ff;
    logic [2:0] map_ds2_ff;
    logic [2:0] map_sub_ff;
    logic [4:0] map_port_ff;
    logic map_valid_ff;
    logic int_oe_ff;
    logic int_out_ff;
    logic dev_rst_ff;
    logic standby_ff;
    logic sbi_ff;
    logic [2:0] hmvip_ff;
    logic opt_bad_ff;

    // ==========================================================
    // Global software reset bit, cleared by hardware reset
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            swrst_ff <= tlm_pkg::GLOBAL_RESET_RESET[tlm_pkg::SWRST_BIT];
        end else if (wr_en && hit(idx, tlm_pkg::IDX_GLOBAL_RESET)) begin
            swrst_ff <= pwdata[tlm_pkg::SWRST_BIT];
        end
    end

    // Global configuration: master interrupt enable and option field
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            master_interrupt_enable_ff <= 1'b0;
            sysopt_ff <= tlm_pkg::SYSOPT_RESET;
        end else if (wr_en && hit(idx, tlm_pkg::IDX_GLOBAL_CONFIG)) begin
            master_interrupt_enable_ff <= pwdata[tlm_pkg::MASTER_INTERRUPT_ENABLE_BIT];
            sysopt_ff <= pwdata[tlm_pkg::SYSOPT_LSB +: 2];
        end
    end

    // Tributary query: E1 flag, SPE number and link number
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            query_ff <= tlm_pkg::MAP_QUERY_RESET;
        end else if (wr_en && hit(idx, tlm_pkg::IDX_MAP_QUERY)) begin
            query_ff <= pwdata[7:0];
        end
    end

    // ==========================================================
    // Tributary index translation
    logic [2:0] m_tug2;
    logic [2:0] m_tu;
    logic [2:0] m_ds2;
    logic [2:0] m_sub;
    logic [4:0] m_port;
    logic m_valid;

    tlm_trib_map u_map (
        .spe_idx(query_ff[tlm_pkg::QRY_SPE_LSB +: 2]),
        .link_idx(query_ff[4:0]),
        .e1_mode(query_ff[tlm_pkg::QRY_E1_BIT]),
        .tug2_idx(m_tug2),
        .tu_idx(m_tu),
        .ds2_idx(m_ds2),
        .sub_idx(m_sub),
        .port_idx(m_port),
        .valid(m_valid)
    );

    // Result registers follow the query one cycle later
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            map_tug2_ff <= 3'h0;
            map_tu_ff <= 3'h0;
            map_ds2_ff <= 3'h0;
            map_sub_ff <= 3'h0;
            map_port_ff <= 5'h00;
            map_valid_ff <= 1'b0;
        end else begin
            map_tug2_ff <= m_tug2;
            map_tu_ff <= m_tu;
            map_ds2_ff <= m_ds2;
            map_sub_ff <= m_sub;
            map_port_ff <= m_port;
            map_valid_ff <= m_valid;
        end
    end

    // ==========================================================
    // Device reset and standby follow the software reset bit
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            dev_rst_ff <= 1'b1;
            standby_ff <= 1'b0;
        end else begin
            dev_rst_ff <= swrst_ff;
            standby_ff <= swrst_ff;
        end
    end

    // Open-drain interrupt: line pulled low only while enabled
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            int_oe_ff <= 1'b0;
            int_out_ff <= 1'b0;
        end else begin
            int_oe_ff <= master_interrupt_enable_ff && int_req && !swrst_ff;
            int_out_ff <= 1'b0;
        end
    end

    // ==========================================================
    // System-side interface selection per SPE
    logic [2:0] hd_mode;
    genvar g;
    generate
        for (g = 0; g < tlm_pkg::NUM_SPE; g++) begin : g_spe
            assign hd_mode[g] = (spe_operating_mode[3*g +: 3] == tlm_pkg::OPMODE_HD_FRAMER);
        end
    endgenerate

    logic hmvip_opt;
    assign hmvip_opt = (sysopt_ff == tlm_pkg::SYSOPT_HMVIP) || (sysopt_ff == tlm_pkg::SYSOPT_SBI_HMVIP);

    // Non-framer SPEs never get their H-MVIP port enabled
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sbi_ff <= 1'b1;
            hmvip_ff <= 3'h0;
            opt_bad_ff <= 1'b0;
        end else begin
            sbi_ff <= (sysopt_ff == tlm_pkg::SYSOPT_SBI) || (sysopt_ff == tlm_pkg::SYSOPT_SBI_HMVIP);
            hmvip_ff <= (hmvip_opt && !swrst_ff) ? hd_mode : 3'h0;
            // Reserved code, or H-MVIP with any SPE not in framer mode
            opt_bad_ff <= (sysopt_ff == tlm_pkg::SYSOPT_RESERVED) || (hmvip_opt && (hd_mode != 3'h7));
        end
    end

    // ==========================================================
    // Read data mux; unused bits read as zero
    logic [7:0] rd_byte;
    logic rd_hit;
    always_comb begin
        rd_byte = 8'h00;
        rd_hit = 1'b1;
        case (idx)
            tlm_pkg::IDX_REVISION: rd_byte = {TYPE_CODE, VERSION_CODE};
            tlm_pkg::IDX_GLOBAL_RESET: rd_byte = {7'h00, swrst_ff};
            tlm_pkg::IDX_GLOBAL_CONFIG: rd_byte = {master_interrupt_enable_ff, 5'h00, sysopt_ff};
            tlm_pkg::IDX_STATUS: rd_byte = {2'h0, map_valid_ff, opt_bad_ff, int_req, hmvip_ff};
            tlm_pkg::IDX_MAP_QUERY: rd_byte = query_ff;
            tlm_pkg::IDX_MAP_TELECOM: rd_byte = {2'h0, map_tu_ff, map_tug2_ff};
            tlm_pkg::IDX_MAP_M13: rd_byte = {2'h0, map_sub_ff, map_ds2_ff};
            tlm_pkg::IDX_MAP_HMVIP: rd_byte = {3'h0, map_port_ff};
            default: rd_hit = 1'b0;
        endcase
    end

    // APB answer: one wait-free access phase after each setup
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
        end else begin
            pready_ff <= setup_ph;
            if (setup_ph) begin
                // Test space answers zero without error
                pslverr_ff <= !aligned || (!test_sel && !rd_hit);
                prdata_ff <= (aligned && !test_sel && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
            end
        end
    end

    // ==========================================================
    // Outputs
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign interrupt_output_n_o = int_out_ff;
    assign interrupt_output_n_oe = int_oe_ff;
    assign device_reset = dev_rst_ff;
    assign standby = standby_ff;
    assign sbi_select = sbi_ff;
    assign hmvip_select = hmvip_ff;
    assign option_invalid = opt_bad_ff;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    version_code_a: assert property (
        setup_ph && !pwrite && aligned && !test_sel && hit(idx, tlm_pkg::IDX_REVISION)
        |=> prdata_ff[3:0] == VERSION_CODE && pready_ff)
        else $error("version code read wrong");

    type_code_a: assert property (
        setup_ph && !pwrite && aligned && !test_sel && hit(idx, tlm_pkg::IDX_REVISION)
        |=> prdata_ff[7:4] == TYPE_CODE)
        else $error("type code read wrong");

    test_space_a: assert property (
        setup_ph && aligned && test_sel |=> prdata_ff == 32'h00000000 && !pslverr_ff)
        else $error("test space answered");

    ro_write_a: assert property (
        wr_en && hit(idx, tlm_pkg::IDX_REVISION)
        |=> $stable(swrst_ff) && $stable(master_interrupt_enable_ff) && $stable(sysopt_ff))
        else $error("read-only write changed state");

    swrst_hold_a: assert property (
        swrst_ff [*2] |-> dev_rst_ff && standby_ff)
        else $error("software reset not held");

    hw_clear_a: assert property (@(posedge clk_sys) disable iff (1'b0)
        reset |=> !swrst_ff && !master_interrupt_enable_ff && sysopt_ff == tlm_pkg::SYSOPT_RESET)
        else $error("hardware reset left bits set");

    int_gate_a: assert property (
        !master_interrupt_enable_ff |=> !int_oe_ff ##0 !interrupt_output_n_o)
        else $error("interrupt driven while disabled");

    int_fire_a: assert property (
        master_interrupt_enable_ff && int_req && !swrst_ff |=> int_oe_ff)
        else $error("interrupt not driven");

    hmvip_mask_a: assert property (
        $past(swrst_ff) == 1'b0 && !$past(hmvip_opt) |-> hmvip_ff == 3'h0)
        else $error("H-MVIP enabled without option");

    link_sum_a: assert property (
        map_valid_ff && !$past(query_ff[tlm_pkg::QRY_E1_BIT])
        |-> 5'($past(query_ff[4:0])) == 5'(5'd7 * 5'(map_tu_ff - 3'h1)) + 5'(map_tug2_ff))
        else $error("T1 link index mismatch");

    link_e1_a: assert property (
        map_valid_ff && $past(query_ff[tlm_pkg::QRY_E1_BIT])
        |-> 5'($past(query_ff[4:0])) == 5'(5'h07 * 5'(map_tu_ff - 3'h1)) + 5'(map_tug2_ff))
        else $error("E1 link index mismatch");

    m13_link_a: assert property (
        map_valid_ff
        |-> 5'($past(query_ff[4:0])) == 5'(5'(map_ds2_ff - 3'h1) * ($past(query_ff[tlm_pkg::QRY_E1_BIT]) ?
            5'(tlm_pkg::E1_PER_DS2) : 5'(tlm_pkg::T1_PER_DS2))) + 5'(map_sub_ff))
        else $error("M13 link index mismatch");

    port_group_a: assert property (
        map_valid_ff
        |-> map_port_ff >= 5'(5'h07 * 5'($past(query_ff[tlm_pkg::QRY_SPE_LSB +: 2]))) - 5'h06
            && map_port_ff <= 5'(5'h07 * 5'($past(query_ff[tlm_pkg::QRY_SPE_LSB +: 2]))))
        else $error("port group out of range");

    cfg_readback_a: assert property (
        wr_en && hit(idx, tlm_pkg::IDX_GLOBAL_CONFIG)
        |=> master_interrupt_enable_ff == $past(pwdata[tlm_pkg::MASTER_INTERRUPT_ENABLE_BIT])
            && sysopt_ff == $past(pwdata[tlm_pkg::SYSOPT_LSB +: 2]))
        else $error("configuration write lost");

    sbi_option_a: assert property (
        sysopt_ff == tlm_pkg::SYSOPT_SBI
        |=> sbi_ff && hmvip_ff == 3'h0 && !opt_bad_ff)
        else $error("system bus option not applied");

    reserved_option_a: assert property (
        sysopt_ff == tlm_pkg::SYSOPT_RESERVED
        |=> opt_bad_ff && !sbi_ff)
        else $error("reserved option not flagged");
endmodule : tlm_master_regs
`default_nettype wire

// ==== tb/tlm_host_model.sv ====
/*
  Host processor model: APB master tasks for the master register bank.
  Assumes one bench process calls xfer at a time, all on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module tlm_host_model (
    input wire logic clk_sys,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [15:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    int stalls = 0;
    // ==========================================================
    // Idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0000;
        pwdata = 32'h00000000;
    end
    // One transfer: setup, access held until pready is sampled high
    task automatic xfer(input logic wr, input logic [15:0] addr, input logic [7:0] wd,
                        output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= {24'h000000, wd};
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) stalls++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Stale data is not left on the bus
        pwdata <= ~{24'h000000, wd};
    endtask : xfer
endmodule : tlm_host_model
`default_nettype wire

// ==== tb/top_level_master_registers_bench.sv ====
/*
  Self-checking bench for the master register bank.
  Assumes the host model drives APB and the bench drives the rest.
*/
`timescale 1ns/1ps
`default_nettype none
module top_level_master_registers_bench;
    typedef struct {logic [1:0] opt; logic [8:0] mode; logic sbi; logic [2:0] hm; logic inv;} tlm_row_t;
    localparam logic [3:0] VER = 4'h3; // Arbitrary value
    localparam logic [3:0] TYP = 4'hA; // Arbitrary value
    logic clk_sys, reset, psel, penable, pwrite, pready, pslverr, int_req, rerr;
    logic interrupt_output_n_o, interrupt_output_n_oe, device_reset, standby, sbi_select, option_invalid;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [8:0] spe_operating_mode;
    logic [2:0] hmvip_select;
    int err_total = 0;
    int samples_checked = 0;
    tlm_row_t rows [6] = '{'{tlm_pkg::SYSOPT_RESERVED, 9'h000, 1'b0, 3'h0, 1'b1},
        '{tlm_pkg::SYSOPT_HMVIP, 9'h000, 1'b0, 3'h7, 1'b0}, '{tlm_pkg::SYSOPT_HMVIP, 9'h008, 1'b0, 3'h5, 1'b1},
        '{tlm_pkg::SYSOPT_SBI_HMVIP, 9'h040, 1'b1, 3'h3, 1'b1},
        '{tlm_pkg::SYSOPT_SBI_HMVIP, 9'h000, 1'b1, 3'h7, 1'b0}, '{tlm_pkg::SYSOPT_SBI, 9'h1FF, 1'b1, 3'h0, 1'b0}};
    logic [7:0] qv [9] = '{8'h21, 8'h7C, 8'h48, 8'hB5, 8'hE4, 8'hCA, 8'h3D, 8'hB6, 8'h01};

    tlm_master_regs #(.VERSION_CODE(VER), .TYPE_CODE(TYP)) dut (.clk_sys, .reset, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .int_req, .spe_operating_mode, .interrupt_output_n_o,
        .interrupt_output_n_oe, .device_reset, .standby, .sbi_select, .hmvip_select, .option_invalid);
    tlm_host_model host (.clk_sys, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

    // ==========================================================
    // Clock, 5 ns period
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // Byte address of a register index
    function automatic logic [15:0] ad(input logic [12:0] idx);
        return {1'b0, idx, 2'b00};
    endfunction : ad
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish
    // Bus access; a hung transfer ends the run
    task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] wd);
        host.xfer(wr, a, wd, rdat, rerr);
        if (host.stalls != 0) begin
            err_total++;
            tally_and_finish();
        end
    endtask : acc
    task automatic settle();
        repeat (3) @(posedge clk_sys);
    endtask : settle

    // ==========================================================
    // Main sequence
    initial begin
        int l, per, sp;
        logic ok;
        reset = 1'b1;
        int_req = 1'b0;
        spe_operating_mode = 9'h000;
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        settle();
        // System-side option table
        foreach (rows[i]) begin
            spe_operating_mode <= rows[i].mode;
            acc(1'b1, ad(tlm_pkg::IDX_GLOBAL_CONFIG), {6'h00, rows[i].opt});
            settle();
            chk(sbi_select, rows[i].sbi);
            chk(hmvip_select, rows[i].hm);
            chk(option_invalid, rows[i].inv);
            acc(1'b0, ad(tlm_pkg::IDX_GLOBAL_CONFIG), 8'h00);
            chk(rdat & 32'h83, rows[i].opt);
        end
        $display("test options done");
        // Tributary index query
        foreach (qv[i]) begin
            acc(1'b1, ad(tlm_pkg::IDX_MAP_QUERY), qv[i]);
            l = int'(qv[i][4:0]) - 1;
            sp = int'(qv[i][6:5]);
            per = qv[i][7] ? 3 : 4;
            ok = sp != 0 && l >= 0 && l < 7 * per;
            acc(1'b0, ad(tlm_pkg::IDX_MAP_QUERY), 8'h00);
            chk(rdat, qv[i]);
            acc(1'b0, ad(tlm_pkg::IDX_STATUS), 8'h00);
            chk(rdat[5], ok);
            if (ok) begin
                acc(1'b0, ad(tlm_pkg::IDX_MAP_TELECOM), 8'h00);
                chk(rdat, 32'((l / 7 + 1) * 8 + l % 7 + 1));
                acc(1'b0, ad(tlm_pkg::IDX_MAP_M13), 8'h00);
                chk(rdat, 32'((l % per + 1) * 8 + l / per + 1));
                acc(1'b0, ad(tlm_pkg::IDX_MAP_HMVIP), 8'h00);
                chk(rdat, 32'(7 * (sp - 1) + l / per + 1));
            end
        end
        $display("test query done");
        // Hardware reset clears software reset and configuration
        acc(1'b1, ad(tlm_pkg::IDX_GLOBAL_CONFIG), 8'h81);
        acc(1'b1, ad(tlm_pkg::IDX_GLOBAL_RESET), 8'h01);
        reset <= 1'b1;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        settle();
        chk({device_reset, standby, sbi_select, hmvip_select, option_invalid}, 7'h10);
        chk(interrupt_output_n_oe, 1'b0);
        acc(1'b0, ad(tlm_pkg::IDX_GLOBAL_RESET), 8'h00);
        chk(rdat, tlm_pkg::GLOBAL_RESET_RESET);
        acc(1'b0, ad(tlm_pkg::IDX_GLOBAL_CONFIG), 8'h00);
        chk(rdat & 32'h83, tlm_pkg::SYSOPT_RESET);
        chk(rerr, 1'b0);
        $display("test reset done");
        // Revision is fixed and ignores writes
        acc(1'b1, ad(tlm_pkg::IDX_REVISION), 8'hFF);
        acc(1'b0, ad(tlm_pkg::IDX_REVISION), 8'h00);
        chk(rdat, {24'h000000, TYP, VER});
        // Ones in unused bits change nothing
        acc(1'b1, ad(tlm_pkg::IDX_GLOBAL_CONFIG), 8'h7E);
        settle();
        chk(sbi_select, 1'b1);
        acc(1'b0, ad(tlm_pkg::IDX_GLOBAL_CONFIG), 8'h00);
        chk(rdat & 32'h83, 32'h02);
        $display("test fixed done");
        // Interrupt pin follows master enable and request
        int_req <= 1'b1;
        acc(1'b1, ad(tlm_pkg::IDX_GLOBAL_CONFIG), 8'h82);
        settle();
        chk({interrupt_output_n_oe, interrupt_output_n_o}, 2'b10);
        int_req <= 1'b0;
        settle();
        chk(interrupt_output_n_oe, 1'b0);
        int_req <= 1'b1;
        acc(1'b1, ad(tlm_pkg::IDX_GLOBAL_CONFIG), 8'h02);
        settle();
        chk(interrupt_output_n_oe, 1'b0);
        $display("test interrupt done");
        // Software reset holds until software clears it
        acc(1'b1, ad(tlm_pkg::IDX_GLOBAL_CONFIG), 8'h82);
        acc(1'b1, ad(tlm_pkg::IDX_GLOBAL_RESET), 8'h01);
        settle();
        chk({device_reset, standby, interrupt_output_n_oe}, 3'b110);
        acc(1'b0, ad(tlm_pkg::IDX_GLOBAL_RESET), 8'h00);
        chk(rdat, 32'h01);
        acc(1'b1, ad(tlm_pkg::IDX_GLOBAL_RESET), 8'h00);
        settle();
        chk({device_reset, standby, interrupt_output_n_oe}, 3'b001);
        $display("test soft reset done");
        // Test space and refused addresses
        acc(1'b1, ad(13'h1001), 8'h01);
        settle();
        chk(device_reset, 1'b0);
        acc(1'b0, ad(13'h1000), 8'h00);
        chk(rdat, 32'h00000000);
        chk(rerr, 1'b0);
        acc(1'b0, ad(13'h0008), 8'h00);
        chk(rerr, 1'b1);
        acc(1'b0, 16'h0001, 8'h00);
        chk(rerr, 1'b1);
        acc(1'b0, 16'h8000, 8'h00);
        chk(rdat, 32'h00000000);
        chk(rerr, 1'b1);
        $display("test address done");
        tally_and_finish();
    end
endmodule : top_level_master_registers_bench
`default_nettype wire
